/* pkg/scs_defs.svh */
// Offsets, field positions, reset values and timing counts of the converter sequencer.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

`define SCS_OFF_CTRL      8'h00
`define SCS_OFF_MUX       8'h04
`define SCS_OFF_RES_LO    8'h08
`define SCS_OFF_RES_HI    8'h0C
`define SCS_OFF_SFR       8'h10

`define SCS_CTRL_EN       7
`define SCS_CTRL_START    6
`define SCS_CTRL_AUTO     5
`define SCS_CTRL_FLAG     4
`define SCS_MUX_REF_HI    7
`define SCS_MUX_REF_LO    6
`define SCS_MUX_LADJ      5
`define SCS_MUX_CHAN_HI   4
`define SCS_SFR_TRIG_HI   7
`define SCS_SFR_TRIG_LO   5

`define SCS_RST_BYTE      8'h00
`define SCS_RST_RESULT    10'h000

`define SCS_NORMAL_CYCLES 5'h0D
`define SCS_FIRST_CYCLES  5'h19
`define SCS_PRESCALE_DIV  7'h08

`define SCS_FREE_RUN_CODE 3'h0
`define SCS_SE_LAST       5'h07
`define SCS_G10_FIRST     5'h08
`define SCS_G10_LAST      5'h0B
`define SCS_G200_FIRST    5'h0C
`define SCS_G200_LAST     5'h0F
`define SCS_BANDGAP_CODE  5'h1E
`define SCS_GROUND_CODE   5'h1F

`endif

/* pkg/scs_pkg.sv */
// Types shared by the converter sequencer files.
package scs_pkg;

	typedef enum logic [1:0] {
		SCS_GAIN_1X   = 2'h0,
		SCS_GAIN_10X  = 2'h1,
		SCS_GAIN_200X = 2'h2
	} scs_gain_t;

	typedef struct packed {
		logic [1:0] reference;
		logic [4:0] channel;
	} scs_mux_t;

	typedef struct packed {
		logic      single_ended;
		scs_gain_t gain;
	} scs_path_t;

	typedef enum logic [2:0] {
		SCS_IDLE = 3'h1,
		SCS_WAIT = 3'h2,
		SCS_CONV = 3'h4
	} scs_state_t;

endpackage : scs_pkg

/* rtl/scs_prescaler.sv */
// Converter clock prescaler producing a one-cycle tick per converter clock.
`include "scs_defs.svh"

module scs_prescaler (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Control
	input  wire logic clear,
	// Converter clock tick
	output logic      tick
);
	import scs_pkg::*;

	logic [6:0] cnt_q;

	always_ff @(posedge clk) begin
		if (!resetn || clear) begin
			cnt_q <= 7'h00;
		end else if (cnt_q == `SCS_PRESCALE_DIV - 7'h01) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || clear) begin
			tick <= 1'b0;
		end else begin
			tick <= (cnt_q == `SCS_PRESCALE_DIV - 7'h01);
		end
	end

endmodule : scs_prescaler

/* rtl/scs_sequencer.sv */
// Conversion sequencer with APB register file around a 10-bit successive-approximation converter.
`include "scs_defs.svh"

module scs_sequencer #(
	parameter logic [2:0] FREE_RUN_CODE = `SCS_FREE_RUN_CODE
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Trigger sources, indexed by trigger_source_select
	input  wire logic [7:0]        trigger_sources,
	// Analog front end
	input  wire logic [9:0]        sar_code,
	output logic                   analog_enable,
	output scs_pkg::scs_mux_t      analog_select,
	output scs_pkg::scs_path_t     analog_path,
	output logic                   conversion_done
);
	import scs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers and state.

	logic       converter_enable_q;
	logic       start_conversion_q;
	logic       auto_trigger_enable_q;
	logic       conversion_complete_flag_q;
	logic       left_adjust_result_q;
	scs_mux_t   input_select_q;
	logic [2:0] trigger_source_select_q;
	logic [9:0] result_q;
	logic       lock_q;
	logic       first_q;
	logic       trig_prev_q;
	logic [4:0] tick_cnt_q;
	logic [9:0] code_meta_q;
	logic [9:0] code_sync_q;
	scs_state_t state_q;

	logic       tick;
	logic       acc_done;
	logic       wr_en;
	logic       rd_en;
	logic       sw_start;
	logic       trig_lvl;
	logic       trig_edge;
	logic       free_run;
	logic       complete;
	logic [4:0] conv_len;
	logic [7:0] res_hi;
	logic [7:0] res_lo;
	logic [7:0] rd_byte;
	logic       mapped;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode; one wait state so that read data comes from a flip-flop.

	assign acc_done = psel && penable && pready;
	assign wr_en    = acc_done && pwrite;
	assign rd_en    = acc_done && !pwrite;

	always_comb begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		unique case (paddr)
			`SCS_OFF_CTRL: rd_byte = {converter_enable_q, start_conversion_q, auto_trigger_enable_q,
			                          conversion_complete_flag_q, 4'h0};
			`SCS_OFF_MUX: rd_byte = {input_select_q.reference, left_adjust_result_q, input_select_q.channel};
			`SCS_OFF_RES_LO: rd_byte = res_lo;
			`SCS_OFF_RES_HI: rd_byte = res_hi;
			`SCS_OFF_SFR: rd_byte = {trigger_source_select_q, 5'h00};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			prdata  <= {24'h00_0000, rd_byte};
			pslverr <= !mapped;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control bits written by software.

	always_ff @(posedge clk) begin
		if (!resetn) begin
			converter_enable_q      <= 1'b0;
			auto_trigger_enable_q   <= 1'b0;
			left_adjust_result_q    <= 1'b0;
			input_select_q          <= scs_mux_t'(7'h00);
			trigger_source_select_q <= 3'h0;
		end else if (wr_en && paddr == `SCS_OFF_CTRL) begin
			converter_enable_q    <= pwdata[`SCS_CTRL_EN];
			auto_trigger_enable_q <= pwdata[`SCS_CTRL_AUTO];
		end else if (wr_en && paddr == `SCS_OFF_MUX) begin
			input_select_q       <= {pwdata[`SCS_MUX_REF_HI:`SCS_MUX_REF_LO], pwdata[`SCS_MUX_CHAN_HI:0]};
			left_adjust_result_q <= pwdata[`SCS_MUX_LADJ];
		end else if (wr_en && paddr == `SCS_OFF_SFR) begin
			trigger_source_select_q <= pwdata[`SCS_SFR_TRIG_HI:`SCS_SFR_TRIG_LO];
		end
	end

	// A start written while disabled is dropped, since no converter clock runs.
	assign sw_start = wr_en && paddr == `SCS_OFF_CTRL && pwdata[`SCS_CTRL_START]
	                  && pwdata[`SCS_CTRL_EN] && converter_enable_q;

	////////////////////////////////////////////////////////////////////////////////
	// Trigger selection and edge detection; sources are on this clock.

	assign trig_lvl  = trigger_sources[trigger_source_select_q];
	assign free_run  = auto_trigger_enable_q && trigger_source_select_q == FREE_RUN_CODE;
	// A flag source left set gives no new edge until it is cleared and set again.
	assign trig_edge = auto_trigger_enable_q && !free_run && converter_enable_q
	                   && trig_lvl && !trig_prev_q && state_q != SCS_CONV;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler, held while disabled and restarted by a trigger edge.

	scs_prescaler u_prescaler (
		.clk    (clk),
		.resetn (resetn),
		.clear  (!converter_enable_q || trig_edge),
		.tick   (tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencing.

	assign conv_len = first_q ? `SCS_FIRST_CYCLES : `SCS_NORMAL_CYCLES;
	assign complete = state_q == SCS_CONV && tick && tick_cnt_q == conv_len - 5'h01;

	always_ff @(posedge clk) begin
		if (!resetn || !converter_enable_q) begin
			state_q    <= SCS_IDLE;
			tick_cnt_q <= 5'h00;
		end else begin
			unique case (state_q)
				SCS_IDLE: begin
					if (trig_edge) begin
						state_q    <= SCS_CONV;
						tick_cnt_q <= 5'h00;
					end else if (sw_start) begin
						state_q <= SCS_WAIT;
					end
				end
				SCS_WAIT: begin
					if (tick || trig_edge) begin
						state_q    <= SCS_CONV;
						tick_cnt_q <= 5'h00;
					end
				end
				SCS_CONV: begin
					if (complete) begin
						state_q    <= free_run ? SCS_CONV : SCS_IDLE;
						tick_cnt_q <= 5'h00;
					end else if (tick) begin
						tick_cnt_q <= tick_cnt_q + 5'h01;
					end
				end
				default: begin
					state_q    <= SCS_IDLE;
					tick_cnt_q <= 5'h00;
				end
			endcase
		end
	end

	// The extended first conversion follows every enable.
	always_ff @(posedge clk) begin
		if (!resetn || !converter_enable_q) begin
			first_q <= 1'b1;
		end else if (complete) begin
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || !converter_enable_q) begin
			start_conversion_q <= 1'b0;
		// A start written mid-conversion must not keep the bit up once that conversion ends.
		end else if ((sw_start && state_q != SCS_CONV) || trig_edge) begin
			start_conversion_q <= 1'b1;
		end else if (complete && !free_run) begin
			start_conversion_q <= 1'b0;
		end
	end

	// Setting by hardware wins over a software clear in the same cycle.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			conversion_complete_flag_q <= 1'b0;
		end else if (complete) begin
			conversion_complete_flag_q <= 1'b1;
		end else if (wr_en && paddr == `SCS_OFF_CTRL && pwdata[`SCS_CTRL_FLAG]) begin
			conversion_complete_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			conversion_done <= 1'b0;
		end else begin
			conversion_done <= complete;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Analog selection, frozen while converting so the sample stays on one channel.
	// It reopens at completion, so that free running picks up a new choice for its next conversion.

	always_ff @(posedge clk) begin
		if (!resetn) begin
			analog_enable <= 1'b0;
			analog_select <= scs_mux_t'(7'h00);
			analog_path   <= scs_path_t'(3'h4);
		end else begin
			analog_enable <= converter_enable_q;
			if (converter_enable_q && (state_q != SCS_CONV || complete)) begin
				analog_select <= input_select_q;
				analog_path   <= path_of(input_select_q.channel);
			end
		end
	end

	function automatic scs_path_t path_of(input logic [4:0] ch);
		scs_path_t p;
		p.single_ended = ch <= `SCS_SE_LAST || ch == `SCS_BANDGAP_CODE || ch == `SCS_GROUND_CODE;
		if (ch >= `SCS_G10_FIRST && ch <= `SCS_G10_LAST) begin
			p.gain = SCS_GAIN_10X;
		end else if (ch >= `SCS_G200_FIRST && ch <= `SCS_G200_LAST) begin
			p.gain = SCS_GAIN_200X;
		end else begin
			p.gain = SCS_GAIN_1X;
		end
		return p;
	endfunction : path_of

	////////////////////////////////////////////////////////////////////////////////
	// Result capture with read lock.

	always_ff @(posedge clk) begin
		if (!resetn) begin
			code_meta_q <= `SCS_RST_RESULT;
			code_sync_q <= `SCS_RST_RESULT;
		end else begin
			code_meta_q <= sar_code;
			code_sync_q <= code_meta_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			result_q <= `SCS_RST_RESULT;
		end else if (complete && !lock_q) begin
			result_q <= code_sync_q;
		end
	end

	// Software must read low then high for a coherent pair; a lone high read is fine left-aligned.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lock_q <= 1'b0;
		end else if (rd_en && paddr == `SCS_OFF_RES_LO) begin
			lock_q <= 1'b1;
		end else if (rd_en && paddr == `SCS_OFF_RES_HI) begin
			lock_q <= 1'b0;
		end
	end

	// Alignment is applied on read, so toggling it reformats the held result.
	assign res_hi = left_adjust_result_q ? result_q[9:2] : {6'h00, result_q[9:8]};
	assign res_lo = left_adjust_result_q ? {result_q[1:0], 6'h00} : result_q[7:0];

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_locked_keeps_result;
		complete && lock_q |=> $stable(result_q);
	endproperty
	a_locked_keeps_result: assert property (p_locked_keeps_result) else $error("Result changed while locked.");

	property p_hi_read_unlocks;
		rd_en && paddr == `SCS_OFF_RES_HI |=> !lock_q;
	endproperty
	a_hi_read_unlocks: assert property (p_hi_read_unlocks) else $error("High read left lock set.");

	property p_flag_on_complete;
		complete |=> conversion_complete_flag_q && conversion_done;
	endproperty
	a_flag_on_complete: assert property (p_flag_on_complete) else $error("Flag not set at completion.");

	property p_start_cleared;
		complete && !free_run |=> !start_conversion_q;
	endproperty
	a_start_cleared: assert property (p_start_cleared) else $error("Start bit not cleared.");

	property p_start_high_in_conv;
		state_q == SCS_CONV |-> start_conversion_q;
	endproperty
	a_start_high_in_conv: assert property (p_start_high_in_conv) else $error("Start low during conversion.");

	property p_select_frozen;
		state_q == SCS_CONV && $past(state_q) == SCS_CONV && !$past(complete) |-> $stable(analog_select);
	endproperty
	a_select_frozen: assert property (p_select_frozen) else $error("Channel moved during conversion.");

	property p_disabled_holds;
		!converter_enable_q && !$past(converter_enable_q) |-> $stable(analog_select);
	endproperty
	a_disabled_holds: assert property (p_disabled_holds) else $error("Selection applied while disabled.");

	property p_trig_starts;
		trig_edge |=> state_q == SCS_CONV && tick_cnt_q == 5'h00 && !tick;
	endproperty
	a_trig_starts: assert property (p_trig_starts) else $error("Trigger edge did not start.");

	property p_no_edge_in_conv;
		state_q == SCS_CONV |-> !trig_edge;
	endproperty
	a_no_edge_in_conv: assert property (p_no_edge_in_conv) else $error("Edge accepted mid-conversion.");

	property p_length;
		complete |-> tick_cnt_q == (first_q ? 5'h18 : 5'h0C);
	endproperty
	a_length: assert property (p_length) else $error("Wrong conversion length.");

	property p_prescaler_held;
		!converter_enable_q |=> !tick;
	endproperty
	a_prescaler_held: assert property (p_prescaler_held) else $error("Prescaler ran while disabled.");

	property p_free_run_continues;
		complete && free_run && converter_enable_q |=> state_q == SCS_CONV && start_conversion_q;
	endproperty
	a_free_run_continues: assert property (p_free_run_continues) else $error("Free run stopped.");

	c_locked_discard: cover property (complete && lock_q);
	c_free_run: cover property (complete && free_run);
	c_trigger_start: cover property (trig_edge);
	c_first_conversion: cover property (complete && first_q);

endmodule : scs_sequencer

/* testbench/scs_sequencer_tb.sv */
// Self-checking testbench of the converter sequencer, driving its APB and trigger ports.
`include "scs_defs.svh"

module scs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scs_pkg::*;

	logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic        analog_enable, conversion_done, rerr;
	logic [7:0]  paddr, trigger_sources;
	logic [31:0] pwdata, prdata, rdat;
	logic [9:0]  sar_code;
	scs_mux_t    analog_select;
	scs_path_t   analog_path;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;
	int          t0;

	scs_sequencer dut (
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.trigger_sources(trigger_sources), .sar_code(sar_code), .analog_enable(analog_enable),
		.analog_select(analog_select), .analog_path(analog_path), .conversion_done(conversion_done)
	);

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic in_win(input int n, input int lo, input int hi, input string what);
		checked++;
		if (n < lo || n > hi) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s took %0d cycles", $time, what, n);
		end
	endtask : in_win

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	task automatic timeout(input string what);
		n_mismatch++;
		$display("CHECK FAILED at %0t: no answer in %s", $time, what);
		stop_test();
	endtask : timeout

	// Entered just after a rising edge; ends one idle cycle later so that psel never gets two values at one edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			timeout("bus");
		end
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, a, {24'h0, d});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		apb(1'h0, a, 32'h0);
		chk(rdat, {24'h0, exp}, what);
		chk({31'h0, rerr}, 32'h0, what);
	endtask : rd

	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (conversion_done !== 1'h1 && n < 400);
		if (conversion_done !== 1'h1) begin
			timeout("conversion");
		end
	endtask : wait_done

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({29'h0, analog_path}, 32'h4, "path after reset");
		rd(`SCS_OFF_CTRL, 8'h00, "ctrl reset");
		rd(`SCS_OFF_MUX, 8'h00, "mux reset");
		rd(`SCS_OFF_RES_LO, 8'h00, "low reset");
		rd(`SCS_OFF_RES_HI, 8'h00, "high reset");
		rd(`SCS_OFF_SFR, 8'h00, "sfr reset");
		apb(1'h1, 8'h14, 32'hFF);
		chk({31'h0, rerr}, 32'h1, "unmapped write");
		apb(1'h0, 8'h14, 32'h0);
		chk({31'h0, rerr}, 32'h1, "unmapped read");
		chk(rdat, 32'h0, "unmapped data");
	endtask : t_reset

	task automatic t_enable();
		logic [4:0] code [6] = '{5'h00, 5'h0B, 5'h0C, 5'h10, 5'h1E, 5'h1F};
		logic [2:0] path [6] = '{3'h4, 3'h1, 3'h2, 3'h0, 3'h4, 3'h4};
		wr(`SCS_OFF_MUX, 8'h49);
		repeat (4) @(posedge clk);
		chk({25'h0, analog_select}, 32'h0, "select while off");
		wr(`SCS_OFF_CTRL, 8'h80);
		repeat (2) @(posedge clk);
		chk({31'h0, analog_enable}, 32'h1, "enable out");
		chk({25'h0, analog_select}, {25'h0, 2'h1, 5'h09}, "select applied");
		for (int i = 0; i < 6; i++) begin
			wr(`SCS_OFF_MUX, {3'h0, code[i]});
			repeat (2) @(posedge clk);
			chk({29'h0, analog_path}, {29'h0, path[i]}, "path decode");
		end
	endtask : t_enable

	task automatic t_single();
		sar_code <= 10'h2A5;
		wr(`SCS_OFF_CTRL, 8'hC0);
		t0 = cyc;
		rd(`SCS_OFF_CTRL, 8'hC0, "start busy");
		wait_done();
		in_win(cyc - t0, 195, 215, "first conversion");
		rd(`SCS_OFF_CTRL, 8'h90, "flag set start clear");
		rd(`SCS_OFF_RES_LO, 8'hA5, "right low");
		rd(`SCS_OFF_RES_HI, 8'h02, "right high");
		wr(`SCS_OFF_MUX, 8'h20);
		rd(`SCS_OFF_RES_LO, 8'h40, "left low");
		sar_code <= 10'h15A;
		wr(`SCS_OFF_CTRL, 8'hD0);
		t0 = cyc;
		repeat (10) @(posedge clk);
		wr(`SCS_OFF_MUX, 8'h25);
		chk({25'h0, analog_select}, 32'h0, "channel held");
		wait_done();
		in_win(cyc - t0, 100, 120, "normal conversion");
		repeat (2) @(posedge clk);
		chk({25'h0, analog_select}, 32'h5, "channel after");
		rd(`SCS_OFF_CTRL, 8'h90, "flag on lost result");
		rd(`SCS_OFF_RES_HI, 8'hA9, "locked high");
		wr(`SCS_OFF_CTRL, 8'hD0);
		wait_done();
		rd(`SCS_OFF_RES_LO, 8'h80, "new low");
		rd(`SCS_OFF_RES_HI, 8'h56, "new high");
	endtask : t_single

	task automatic t_trigger();
		int n;
		wr(`SCS_OFF_SFR, 8'h20);
		wr(`SCS_OFF_CTRL, 8'hB0);
		rd(`SCS_OFF_CTRL, 8'hA0, "auto idle");
		trigger_sources <= 8'h02;
		n = 0;
		// A second edge in mid-conversion must not lengthen or restart it.
		do begin
			@(posedge clk);
			n++;
			if (n == 30) trigger_sources <= 8'h00;
			if (n == 40) trigger_sources <= 8'h02;
		end while (conversion_done !== 1'h1 && n < 400);
		in_win(n, 100, 112, "triggered conversion");
		n = 0;
		repeat (150) begin
			@(posedge clk);
			if (conversion_done === 1'h1) n++;
		end
		chk(n, 32'h0, "restart on held level");
		trigger_sources <= 8'h00;
		@(posedge clk);
		trigger_sources <= 8'h02;
		rd(`SCS_OFF_CTRL, 8'hF0, "busy after trigger");
		wait_done();
		wr(`SCS_OFF_CTRL, 8'hF0);
		t0 = cyc;
		wait_done();
		in_win(cyc - t0, 100, 120, "start with auto on");
		trigger_sources <= 8'h00;
	endtask : t_trigger

	task automatic t_free();
		wr(`SCS_OFF_SFR, 8'h00);
		wr(`SCS_OFF_CTRL, 8'hF0);
		wait_done();
		t0 = cyc;
		wait_done();
		in_win(cyc - t0, 100, 112, "free run");
		rd(`SCS_OFF_CTRL, 8'hF0, "free run busy");
		wr(`SCS_OFF_CTRL, 8'h10);
		rd(`SCS_OFF_CTRL, 8'h00, "disabled");
		chk({31'h0, analog_enable}, 32'h0, "enable off");
		// A start written together with the enable is dropped, since no converter clock runs yet.
		wr(`SCS_OFF_CTRL, 8'hC0);
		rd(`SCS_OFF_CTRL, 8'h80, "start dropped while off");
		wr(`SCS_OFF_CTRL, 8'hC0);
		t0 = cyc;
		wait_done();
		in_win(cyc - t0, 195, 215, "first after enable");
	endtask : t_free

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		trigger_sources = 8'h00;
		sar_code = 10'h000;
		repeat (6) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		t_reset();
		t_enable();
		t_single();
		t_trigger();
		t_free();
		stop_test();
	end

endmodule : scs_sequencer_tb
